// ==== verilog/tsrs_defs.svh ====
`ifndef TSRS_DEFS_SVH
`define TSRS_DEFS_SVH

// apb byte offsets
`define TSRS_ADDR_CTRL 12'h000
`define TSRS_ADDR_STATUS 12'h004
`define TSRS_ADDR_POINTER 12'h008
`define TSRS_ADDR_RAM_LO 12'h400
`define TSRS_ADDR_RAM_HI 12'h5fc

// control register fields
`define TSRS_CTRL_MODE_LO 0
`define TSRS_CTRL_EN_LO 2
`define TSRS_CTRL_REQ_LO 4
`define TSRS_CTRL_RESET 6'h00

// status register fields
`define TSRS_STAT_CUR_LO 0
`define TSRS_STAT_ERR_LO 2

// route ram geometry, in 16-bit entries
`define TSRS_RAM_ENTRIES 128
`define TSRS_TX_OFFSET 7'h40
`define TSRS_TDMB_OFFSET 7'h20
`define TSRS_DYN1_SHADOW 7'h20
`define TSRS_DYN2_SHADOW 7'h10
`define TSRS_LEN_STATIC1 6'h3f
`define TSRS_LEN_HALF 6'h1f
`define TSRS_LEN_QUARTER 6'h0f

// channel select codes
`define TSRS_CHANNEL_SELECT_CODE_NONE 3'h0
`define TSRS_CHANNEL_SELECT_CODE_NONE2 3'h7

`endif

// ==== verilog/tsrs_pkg.sv ====
package tsrs_pkg;

    // ram division modes
    typedef enum logic [1:0] {
        TSRS_STATIC_ONE = 2'b00,
        TSRS_DYNAMIC_ONE = 2'b01,
        TSRS_STATIC_TWO = 2'b10,
        TSRS_DYNAMIC_TWO = 2'b11
    } tsrs_mode_t;

    // sequencer states
    typedef enum logic [1:0] {
        TSRS_IDLE = 2'b00,
        TSRS_RUN = 2'b01,
        TSRS_DONE = 2'b10,
        TSRS_ERR = 2'b11
    } tsrs_state_t;

    // one route entry
    typedef struct packed {
        logic rsvd_hi;
        logic swap_pin_direction;
        logic [3:0] strobe_select_bits;
        logic rsvd_lo;
        logic [2:0] channel_select_code;
        logic [3:0] group_length_field;
        logic byte_resolution_flag;
        logic last_entry_flag;
    } tsrs_entry_t;

    // one received bit handed to an internal channel
    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic data;
    } tsrs_rxev_t;

endpackage : tsrs_pkg

// ==== verilog/tsrs_top.sv ====
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "tsrs_defs.svh"

// Operation
// RULE1 - length field holds units minus one: zero is one, all ones sixteen
// RULE2 - resolution flag zero counts bits, one counts bytes
// RULE3 - software sets the last flag in the final entry of each group
// RULE4 - after a last entry, stop and wait for sync, then restart at top
// RULE5 - sync before frame end flags error, halts until a further sync
// RULE6 - software duplicates entries for both directions for same routing
// RULE7 - four ram partitionings: 2, 4, 4 and 8 parts
// RULE8 - static mode: disable channels, rewrite routes, then re-enable
// RULE9 - change request swaps shadow and current at sync, then clears
// RULE10 - after a swap roles exchange and further requests are accepted
// RULE11 - one dynamic tdm: current rx 0-63, tx 128-191, shadows above
// RULE12 - two dynamic tdms: a rx 0-31, a tx 128-159, shadows as listed
// RULE13 - software never writes the area acting as current route
// RULE14 - status register shows which partition is current
// RULE15 - pointer register shows the entry being executed
// RULE16 - two 64 by 16 route memories, uninitialised at power-on
// RULE17 - channel codes 000/111 none with tx off, 1-4 serial, 5-6 mgmt
// RULE18 - strobe bits held for the entry, negated after last entry ends
// RULE19 - swap bit moves the group onto the opposite data pin
// RULE20 - two dynamic tdms: b rx current 64-95, b tx current 192-223
// RULE21 - entries run in order from the top, advancing when count elapses
module tsrs_top
    import tsrs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] tdm_clk,
    input wire logic [1:0] rx_sync,
    input wire logic [1:0] tx_sync,
    input wire logic [1:0] rxpin_i,
    input wire logic [1:0] txpin_i,
    output logic [1:0] rxpin_o,
    output logic [1:0] rxpin_oe,
    output logic [1:0] txpin_o,
    output logic [1:0] txpin_oe,
    input wire logic [5:0] chan_txd,
    output tsrs_rxev_t [1:0] rx_event,
    output logic [3:0] strobe
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic is_ram(input logic [11:0] a);
        is_ram = (a >= `TSRS_ADDR_RAM_LO) && (a <= `TSRS_ADDR_RAM_HI);
    endfunction : is_ram

    // first entry of the current area of sequencer s
    function automatic logic [6:0] area_base(input tsrs_mode_t m,
                                             input logic [1:0] s,
                                             input logic cur);
        logic [6:0] b;
        b = s[0] ? `TSRS_TX_OFFSET : 7'h00;
        case (m)
            TSRS_DYNAMIC_ONE:
                b = b + (cur ? `TSRS_DYN1_SHADOW : 7'h00);
            TSRS_STATIC_TWO:
                b = b + (s[1] ? `TSRS_TDMB_OFFSET : 7'h00);
            TSRS_DYNAMIC_TWO:
                b = b + (s[1] ? `TSRS_TDMB_OFFSET : 7'h00)
                      + (cur ? `TSRS_DYN2_SHADOW : 7'h00);
            default:
                b = b;
        endcase
        area_base = b;
    endfunction : area_base

    // highest pointer inside an area
    function automatic logic [5:0] area_top(input tsrs_mode_t m);
        case (m)
            TSRS_STATIC_ONE: area_top = `TSRS_LEN_STATIC1;
            TSRS_DYNAMIC_TWO: area_top = `TSRS_LEN_QUARTER;
            default: area_top = `TSRS_LEN_HALF;
        endcase
    endfunction : area_top

    ////////////////////////////////////////////////////////////////////////
    // registers and route memory

    logic [15:0] route_ram [`TSRS_RAM_ENTRIES]; // see RULE16
    tsrs_mode_t mode_q;
    logic [1:0] en_q;
    logic [1:0] route_change_request_q;
    logic [1:0] cur_q;
    logic [1:0] err_q;
    logic [1:0] swap_ev;
    logic [3:0] err_ev;
    logic [5:0] ptr_w [4];
    logic [3:0] stb_w [4];
    logic apb_wr;
    logic apb_setup;

    assign apb_setup = psel && penable && !pready;
    assign apb_wr = psel && penable && pready && pwrite;

    // route memory write, no reset
    always_ff @(posedge pclk)
    begin
        if (apb_wr && is_ram(paddr))
            route_ram[paddr[8:2]] <= pwdata[15:0];
    end

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= TSRS_STATIC_ONE;
            en_q <= 2'b00;
        end
        else if (apb_wr && paddr == `TSRS_ADDR_CTRL)
        begin
            mode_q <= tsrs_mode_t'(pwdata[`TSRS_CTRL_MODE_LO +: 2]);
            en_q <= pwdata[`TSRS_CTRL_EN_LO +: 2];
        end
    end

    // change requests: set by software, cleared at the exchange
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            route_change_request_q <= 2'b00;
        else
        begin
            for (int t = 0; t < 2; t++)
            begin
                if (apb_wr && paddr == `TSRS_ADDR_CTRL &&
                    pwdata[`TSRS_CTRL_REQ_LO + t])
                    route_change_request_q[t] <= 1'b1; // see RULE10
                else if (swap_ev[t])
                    route_change_request_q[t] <= 1'b0; // see RULE9
            end
        end
    end

    // current-area select, flips on each exchange
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cur_q <= 2'b00; // see RULE11, RULE12, RULE20
        else if (!en_q[0] && !en_q[1])
            cur_q <= 2'b00;
        else
            cur_q <= cur_q ^ swap_ev; // see RULE10
    end

    // sticky frame errors, write one to clear, a new error wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_q <= 2'b00;
        else
        begin
            for (int t = 0; t < 2; t++)
            begin
                if (err_ev[2*t] || err_ev[2*t+1])
                    err_q[t] <= 1'b1; // see RULE5
                else if (apb_wr && paddr == `TSRS_ADDR_STATUS &&
                         pwdata[`TSRS_STAT_ERR_LO + t])
                    err_q[t] <= 1'b0;
            end
        end
    end

    // apb answer: one wait state, error on unmapped offsets
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (apb_setup)
            begin
                if (paddr == `TSRS_ADDR_CTRL)
                    prdata <= {26'h0, route_change_request_q, en_q, mode_q};
                else if (paddr == `TSRS_ADDR_STATUS)
                    prdata <= {28'h0, err_q, cur_q}; // see RULE14
                else if (paddr == `TSRS_ADDR_POINTER)
                    prdata <= {2'b00, ptr_w[3], 2'b00, ptr_w[2],
                               2'b00, ptr_w[1], 2'b00, ptr_w[0]}; // see RULE15
                else if (is_ram(paddr))
                    prdata <= {16'h0000, route_ram[paddr[8:2]]};
                else
                    pslverr <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link input synchronisers and clock edge finding

    logic [9:0] lnk_meta;
    logic [9:0] lnk_s;
    logic [1:0] clk_d;
    logic [1:0] tick;

    // two flops on every pin input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lnk_meta <= 10'h000;
            lnk_s <= 10'h000;
            clk_d <= 2'b00;
        end
        else
        begin
            lnk_meta <= {txpin_i, rxpin_i, tx_sync, rx_sync, tdm_clk};
            lnk_s <= lnk_meta;
            clk_d <= lnk_s[1:0];
        end
    end

    // rising edge of each tdm clock
    assign tick = lnk_s[1:0] & ~clk_d;

    // exchange at rx sync of a dynamic tdm with a pending request
    assign swap_ev[0] = tick[0] && lnk_s[2] && en_q[0] &&
                        route_change_request_q[0] &&
                        (mode_q == TSRS_DYNAMIC_ONE ||
                         mode_q == TSRS_DYNAMIC_TWO); // see RULE9
    assign swap_ev[1] = tick[1] && lnk_s[3] && en_q[1] &&
                        route_change_request_q[1] &&
                        mode_q == TSRS_DYNAMIC_TWO; // see RULE9

    ////////////////////////////////////////////////////////////////////////
    // sequencers: 0 rx a, 1 tx a, 2 rx b, 3 tx b

    tsrs_rxev_t [1:0] rxev_q;
    logic [1:0] txd_q;
    logic [1:0] txon_q;
    logic [1:0] txswap_q;

    genvar s;
    generate
        for (s = 0; s < 4; s++)
        begin : g_seq
            localparam int T = s / 2;
            tsrs_state_t st_q;
            logic [5:0] ptr_q;
            logic [7:0] bit_q;
            logic [3:0] stb_q;
            logic en;
            logic sync;
            logic start;
            logic step;
            logic [5:0] ptr_c;
            logic [7:0] bit_c;
            logic [7:0] lenm1;
            logic [6:0] idx;
            logic chan_ok;
            tsrs_entry_t ent;

            // partitioning decides which tdm b sequencers run; see RULE7
            assign en = en_q[T] && (T == 0 || mode_q == TSRS_STATIC_TWO ||
                                    mode_q == TSRS_DYNAMIC_TWO);
            assign sync = lnk_s[2 + 2*(s%2) + T];
            assign start = tick[T] && en && sync && st_q != TSRS_RUN;
            assign step = start || (tick[T] && en && !sync &&
                                    st_q == TSRS_RUN); // see RULE21
            assign err_ev[s] = tick[T] && en && sync && st_q == TSRS_RUN;
            assign ptr_c = start ? 6'h00 : ptr_q;
            assign bit_c = start ? 8'h00 : bit_q;
            // a frame opened by the exchange sync already runs the new area
            assign idx = area_base(mode_q, 2'(s), cur_q[T] ^ swap_ev[T]) +
                         {1'b0, ptr_c}; // see RULE9
            assign ent = tsrs_entry_t'(route_ram[idx]);
            // units minus one, bytes scaled by eight; see RULE1, RULE2
            assign lenm1 = ent.byte_resolution_flag ?
                           {1'b0, ent.group_length_field, 3'b111} :
                           {4'h0, ent.group_length_field};
            assign chan_ok = ent.channel_select_code != `TSRS_CHANNEL_SELECT_CODE_NONE &&
                             ent.channel_select_code != `TSRS_CHANNEL_SELECT_CODE_NONE2;
            assign ptr_w[s] = ptr_q;
            assign stb_w[s] = stb_q;

            // entry stepping
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    st_q <= TSRS_IDLE;
                    ptr_q <= 6'h00;
                    bit_q <= 8'h00;
                    stb_q <= 4'h0;
                end
                else if (!en)
                begin
                    st_q <= TSRS_IDLE;
                    ptr_q <= 6'h00;
                    bit_q <= 8'h00;
                    stb_q <= 4'h0;
                end
                else if (err_ev[s])
                begin
                    st_q <= TSRS_ERR; // see RULE5
                    ptr_q <= 6'h00;
                    bit_q <= 8'h00;
                    stb_q <= 4'h0;
                end
                else if (step)
                begin
                    stb_q <= ent.strobe_select_bits; // see RULE18
                    if (bit_c != lenm1)
                    begin
                        st_q <= TSRS_RUN;
                        bit_q <= bit_c + 8'h01;
                        ptr_q <= ptr_c;
                    end
                    else if (ent.last_entry_flag ||
                             ptr_c == area_top(mode_q))
                    begin
                        st_q <= TSRS_DONE; // see RULE4
                        bit_q <= 8'h00;
                        ptr_q <= 6'h00;
                    end
                    else
                    begin
                        st_q <= TSRS_RUN;
                        bit_q <= 8'h00;
                        ptr_q <= ptr_c + 6'h01; // see RULE21
                    end
                end
                else if (tick[T] && st_q != TSRS_RUN)
                    stb_q <= 4'h0; // see RULE18
            end

            if (s % 2 == 0)
            begin : g_rx
                // receive one bit for the selected channel
                always_ff @(posedge pclk or negedge presetn)
                begin
                    if (!presetn)
                        rxev_q[T] <= '0;
                    else
                    begin
                        rxev_q[T].valid <= step && en && chan_ok; // see RULE17
                        rxev_q[T].chan <= ent.channel_select_code;
                        rxev_q[T].data <= ent.swap_pin_direction ?
                                          lnk_s[8 + T] :
                                          lnk_s[6 + T]; // see RULE19
                    end
                end
            end
            else
            begin : g_tx
                // transmit bit of the selected channel
                always_ff @(posedge pclk or negedge presetn)
                begin
                    if (!presetn)
                    begin
                        txd_q[T] <= 1'b0;
                        txon_q[T] <= 1'b0;
                        txswap_q[T] <= 1'b0;
                    end
                    else if (!en || err_ev[s])
                        txon_q[T] <= 1'b0; // see RULE5
                    else if (step)
                    begin
                        txon_q[T] <= chan_ok; // see RULE17
                        txswap_q[T] <= ent.swap_pin_direction;
                        txd_q[T] <= chan_ok ?
                                    chan_txd[ent.channel_select_code - 3'h1] :
                                    1'b0;
                    end
                    else if (tick[T] && st_q != TSRS_RUN)
                        txon_q[T] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pin and strobe outputs

    // swap moves transmit onto the receive pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txpin_o <= 2'b00;
            txpin_oe <= 2'b00;
            rxpin_o <= 2'b00;
            rxpin_oe <= 2'b00;
        end
        else
        begin
            txpin_o <= txd_q & ~txswap_q;
            txpin_oe <= txon_q & ~txswap_q;
            rxpin_o <= txd_q & txswap_q; // see RULE19
            rxpin_oe <= txon_q & txswap_q;
        end
    end

    // strobes are the or of every sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            strobe <= 4'h0;
        else
            strobe <= stb_w[0] | stb_w[1] | stb_w[2] | stb_w[3]; // see RULE18
    end

    assign rx_event = rxev_q;

endmodule : tsrs_top

// ==== tb/tsrs_monitor.sv ====
`timescale 1ns/1ps
module tsrs_monitor
    import tsrs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] rxpin_oe,
    input wire logic [1:0] txpin_oe,
    input wire tsrs_rxev_t [1:0] rx_event,
    input wire logic [3:0] strobe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // apb answer timing
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held past one cycle");
    property p_ready_cause;
        pready |-> $past(psel && penable);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("pready without access phase");
    property p_setup_wait;
        psel && !penable |-> ##1 (psel && penable && !pready) ##1 pready;
    endproperty
    a_setup_wait: assert property (p_setup_wait)
        else $error("pready not on second access cycle");
    property p_err_qual;
        pslverr |-> pready;
    endproperty
    a_err_qual: assert property (p_err_qual)
        else $error("pslverr outside pready");

    ////////////////////////////////////////////////////////////////////////
    // link side
    property p_rx_pulse;
        rx_event[0].valid |=> !rx_event[0].valid;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse)
        else $error("receive event longer than one cycle");
    property p_chan_code;
        rx_event[0].valid |-> rx_event[0].chan inside {[3'h1:3'h6]};
    endproperty
    a_chan_code: assert property (p_chan_code)
        else $error("receive event for unsupported channel code");
    property p_reset_quiet;
        $rose(presetn) |-> strobe == 4'h0 && txpin_oe == 2'h0 && !pready;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active right after reset");
    property p_swap_excl;
        txpin_oe[0] |-> !rxpin_oe[0];
    endproperty
    a_swap_excl: assert property (p_swap_excl)
        else $error("both data pins driven at once");
    property p_strobe_hold;
        $changed(strobe) |=> $stable(strobe) [*8];
    endproperty
    a_strobe_hold: assert property (p_strobe_hold)
        else $error("strobe changed between link ticks");
endmodule : tsrs_monitor

bind tsrs_top tsrs_monitor mon (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .pslverr(pslverr),
    .rxpin_oe(rxpin_oe),
    .txpin_oe(txpin_oe),
    .rx_event(rx_event),
    .strobe(strobe)
);

// ==== tb/tsrs_line.sv ====
`timescale 1ns/1ps
module tsrs_line (
    output logic clk,
    output logic rsync,
    output logic tsync,
    output logic rxd,
    output logic txd,
    input wire logic rxd_o,
    input wire logic rxd_oe,
    input wire logic txd_o,
    input wire logic txd_oe
);
    logic pat;

    // released pin shows a changing or inverted level
    assign rxd = rxd_oe ? rxd_o : pat;
    assign txd = txd_oe ? txd_o : ~txd_o;

    initial
    begin
        clk = 1'b0;
        rsync = 1'b0;
        tsync = 1'b0;
        pat = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one frame: sync on tick 0 and on tick s2, clock still outside frames
    task frame(input int n, input int s2);
        #1;
        for (int i = 0; i < n; i++)
        begin
            rsync = (i == 0) || (i == s2);
            tsync = rsync; // common framing for both sets
            pat = ~pat;
            #24 clk = 1'b1;
            #24 clk = 1'b0;
        end
        rsync = 1'b0;
        tsync = 1'b0;
    endtask : frame
endmodule : tsrs_line

// ==== tb/tsrs_top_bench.sv ====
`timescale 1ns/1ps
`include "tsrs_defs.svh"
`define CHK(a, b) compares++; if ((a) !== (b)) begin n_fail++; $display("mismatch t=%0t got %h exp %h", $time, a, b); end
module tsrs_top_bench
    import tsrs_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [5:0] chan_txd = 6'h04;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lclk, lrs, lts, lrx, ltx;
    logic [1:0] rxpin_o, rxpin_oe, txpin_o, txpin_oe;
    tsrs_rxev_t [1:0] rx_event;
    logic [3:0] strobe;
    logic [31:0] r;
    logic e;
    int n_fail = 0;
    int compares = 0;
    int ev[16];
    int s0, s1, toe, thi, dhi;

    always #2 pclk = ~pclk;

    tsrs_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tdm_clk({2{lclk}}), .rx_sync({2{lrs}}), .tx_sync({2{lts}}),
        .rxpin_i({2{lrx}}), .txpin_i({2{ltx}}), .rxpin_o(rxpin_o),
        .rxpin_oe(rxpin_oe), .txpin_o(txpin_o), .txpin_oe(txpin_oe),
        .chan_txd(chan_txd), .rx_event(rx_event), .strobe(strobe));

    tsrs_line line (.clk(lclk), .rsync(lrs), .tsync(lts), .rxd(lrx),
        .txd(ltx), .rxd_o(rxpin_o[0]), .rxd_oe(rxpin_oe[0]),
        .txd_o(txpin_o[0]), .txd_oe(txpin_oe[0]));

    // tallies of what the link side produced
    always @(posedge pclk)
    begin
        if (rx_event[0].valid === 1'b1) ev[rx_event[0].chan]++;
        if (rx_event[1].valid === 1'b1) ev[8 + rx_event[1].chan]++;
        if (rx_event[0].valid === 1'b1 && rx_event[0].data === 1'b1) dhi++;
        if (strobe[0] === 1'b1) s0++;
        if (strobe[1] === 1'b1) s1++;
        if (txpin_oe[0] === 1'b1) toe++;
        if (txpin_oe[0] === 1'b1 && txpin_o[0] === 1'b1) thi++;
    end

    ////////////////////////////////////////////////////////////////////////
    // apb master: holds request until pready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task went(input int i, input logic [15:0] v);
        apb(1'b1, `TSRS_ADDR_RAM_LO + 12'(i * 4), {16'h0, v});
    endtask : went

    function automatic logic [15:0] ent(input logic [2:0] c,
        input logic [3:0] n, input logic b, input logic l, input logic [3:0] s);
        tsrs_entry_t x;
        x = '0;
        x.channel_select_code = c;
        x.group_length_field = n;
        x.byte_resolution_flag = b;
        x.last_entry_flag = l;
        x.strobe_select_bits = s;
        return x;
    endfunction : ent

    task clr();
        ev = '{default: 0};
        s0 = 0;
        s1 = 0;
        toe = 0;
        thi = 0;
        dhi = 0;
    endtask : clr

    task run(input int n, input int s2);
        line.frame(n, s2);
        repeat (6) @(posedge pclk);
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_regs();
        apb(1'b0, `TSRS_ADDR_CTRL, 32'h0);
        `CHK(r, 32'h0)
        apb(1'b0, `TSRS_ADDR_STATUS, 32'h0);
        `CHK(r, 32'h0)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK({e, r}, 33'h100000000)
        went(127, 16'hffff);
        apb(1'b0, 12'h5fc, 32'h0);
        `CHK(r, 32'h0000ffff)
    endtask : t_regs

    task t_static();
        went(0, ent(3'h2, 4'h0, 1'b1, 1'b0, 4'h0));
        went(1, ent(3'h1, 4'h0, 1'b0, 1'b0, 4'h1));
        went(2, ent(3'h0, 4'h3, 1'b0, 1'b1, 4'h2)); // last flag
        went(64, ent(3'h3, 4'h1, 1'b0, 1'b0, 4'h0));
        went(65, ent(3'h0, 4'h0, 1'b0, 1'b1, 4'h0));
        apb(1'b1, `TSRS_ADDR_CTRL, 32'h4); // enable after routes
        clr();
        run(16, 255);
        run(16, 255);
        `CHK(ev[2], 16)
        `CHK(ev[1], 2)
        `CHK(ev[0] + ev[3] + ev[5], 0)
        `CHK(s0, 24)
        `CHK(s1, 96)
        `CHK(toe, 48)
        `CHK(thi, 48)
        `CHK(dhi, 10)
    endtask : t_static

    task t_err();
        clr();
        run(16, 5);
        `CHK(ev[2], 5)
        apb(1'b0, `TSRS_ADDR_STATUS, 32'h0);
        `CHK(r[2], 1'b1)
        apb(1'b1, `TSRS_ADDR_STATUS, 32'h4);
        apb(1'b0, `TSRS_ADDR_STATUS, 32'h0);
        `CHK(r[2], 1'b0)
        clr();
        run(10, 255);
        `CHK(ev[2], 8)
        apb(1'b0, `TSRS_ADDR_POINTER, 32'h0);
        `CHK(r, 32'h00000002)
    endtask : t_err

    task t_dyn();
        apb(1'b1, `TSRS_ADDR_CTRL, 32'h0);
        went(32, ent(3'h5, 4'h0, 1'b0, 1'b1, 4'h0)); // shadow only
        went(96, ent(3'h0, 4'h0, 1'b0, 1'b1, 4'h0));
        apb(1'b1, `TSRS_ADDR_CTRL, 32'h05);
        apb(1'b1, `TSRS_ADDR_CTRL, 32'h15);
        apb(1'b0, `TSRS_ADDR_CTRL, 32'h0);
        `CHK(r[4], 1'b1)
        run(4, 255);
        apb(1'b0, `TSRS_ADDR_CTRL, 32'h0);
        `CHK(r[4], 1'b0)
        apb(1'b0, `TSRS_ADDR_STATUS, 32'h0);
        `CHK(r[0], 1'b1)
        clr();
        run(4, 255);
        `CHK(ev[5] * 16 + ev[2], 16)
        apb(1'b1, `TSRS_ADDR_CTRL, 32'h15);
        run(16, 255);
        apb(1'b0, `TSRS_ADDR_STATUS, 32'h0);
        `CHK(r[0], 1'b0)
        clr();
        run(16, 255);
        `CHK(ev[2] * 16 + ev[5], 128)
    endtask : t_dyn

    // two dynamic tdms, b shares the line with a
    task t_two();
        apb(1'b1, `TSRS_ADDR_CTRL, 32'h0f);
        went(16, ent(3'h6, 4'h0, 1'b0, 1'b1, 4'h0)); // shadow
        went(48, ent(3'h4, 4'h0, 1'b0, 1'b1, 4'h8));
        went(80, ent(3'h0, 4'h0, 1'b0, 1'b1, 4'h0));
        went(112, ent(3'h0, 4'h0, 1'b0, 1'b1, 4'h0));
        clr();
        run(16, 255);
        `CHK(ev[2] + ev[13] * 16, 24)
        apb(1'b1, `TSRS_ADDR_CTRL, 32'h3f);
        clr();
        run(16, 255);
        `CHK(ev[6] + ev[12] * 16, 17)
        apb(1'b0, `TSRS_ADDR_STATUS, 32'h0);
        `CHK(r[1:0], 2'b11)
    endtask : t_two

    task conclude();
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    initial
    begin
        #60000;
        n_fail++;
        conclude();
    end

    initial
    begin
        clr();
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_static();
        t_err();
        t_dyn();
        t_two();
        conclude();
    end
endmodule : tsrs_top_bench
